//--- sfpc_flash.sv
// Flash end: select gating, edge capture and drive, wide lines, protect and pause
// Operation
// (RULE1) Deselected: all outputs high impedance
// (RULE2) First instruction needs a select falling edge
// (RULE3) Input bits ignored while deselected
// (RULE4) Single line: capture rising, drive falling
// (RULE5) Dual and quad lines are bidirectional
// (RULE6) Quad uses protect and pause pins as data
// (RULE7) Protect bit and low pin block status writes
// (RULE8) Protect bit clear allows status writes
// (RULE9) Quad enable disables write protect function
// (RULE10) Quad enable: shared line is data only
// (RULE11) No dedicated reset: select bit picks function
// (RULE12) Dedicated reset enabled: shared line pauses
// (RULE13) Dedicated reset disabled: select bit picks function
// (RULE14) Pause freezes transfer, keeps received bits
// (RULE15) Paused and selected: output high impedance
// (RULE16) Pause released: transfer resumes
// (RULE17) Function bit zero disables dedicated reset; the code disables it when the bit is one
// (RULE18) Reset low: reset mode, outputs released
// (RULE19) Clock may idle low or high
// (RULE20) Master changes pause only with clock low
`timescale 1ns/1ps
module sfpc_flash import sfpc_pkg::*; #(
   parameter bit HAS_DED_RESET = 1'b1
) (
   sfpc_if.flash           bus,
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [1:0] width,
   input  wire logic       stat_wr,
   input  wire logic [7:0] stat_wdata,
   input  wire logic [7:0] func_reg,
   input  wire logic       pin_select_bit,
   input  wire logic [7:0] tx_byte,
   input  wire logic       tx_load,
   output logic      [7:0] rx_byte,
   output logic            rx_valid,
   output logic      [7:0] stat,
   output logic            stat_wr_rej,
   output logic            reset_active,
   output logic            paused
);
   logic [7:0] stat_q;
   logic       stat_wr_rej_q;
   logic [7:0] tx_hold_q;
   logic       tx_tgl_q;
   logic [7:0] rx_byte_q;
   logic       rx_valid_q;
   logic       rx_seen_q;
   logic       reset_active_q;
   logic       paused_q;
   // Link clock domain
   logic       armed_q;
   logic [7:0] rx_sh_q;
   logic [2:0] rx_cnt_q;
   logic [7:0] rx_word_q;
   logic       rx_tgl_q;
   logic [7:0] tx_sh_q;
   logic [2:0] tx_cnt_q;
   logic       tx_act_q;
   logic       tx_ack_q;

   wire        quad_enable          = stat_q[SFPC_QE_BIT];
   wire        status_write_disable = stat_q[SFPC_SWD_BIT];
   wire        write_protect_n      = bus.dl[SFPC_WP_LINE];
   wire        shared_line          = bus.dl[SFPC_HOLD_LINE];

   // Shared line function select
   wire ded_en       = HAS_DED_RESET & ~func_reg[SFPC_FUNC_RSTDIS_BIT]; // (RULE17)
   wire shared_reset = ~quad_enable & pin_select_bit & ~ded_en; // (RULE11) (RULE12) (RULE13)
   wire shared_pause = ~quad_enable & ~shared_reset; // (RULE10)
   wire rst_pin_act  = (ded_en & ~bus.reset_n) | (shared_reset & ~shared_line); // (RULE18)
   wire hold_act     = shared_pause & ~shared_line & ~bus.cs_n; // (RULE14) (RULE15)

   // Link shift registers and counters are cleared while deselected or in reset mode
   wire link_rst_n   = rst_n & ~bus.cs_n & ~rst_pin_act; // (RULE1) (RULE3) (RULE18)

   // Clock-domain view of pins and link events
   logic [3:0] cs_sync;
   sfpc_sync #(.WIDTH(4)) u_sync_clk (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({hold_act, rst_pin_act, write_protect_n, rx_tgl_q}),
      .q     (cs_sync)
   );
   wire hold_s = cs_sync[3];
   wire rst_s  = cs_sync[2];
   wire wp_n_s = cs_sync[1];
   wire rx_t_s = cs_sync[0];

   // Link-domain view of configuration and the transmit toggle
   logic [3:0] lk_sync;
   sfpc_sync #(.WIDTH(4)) u_sync_link (
      .clk   (bus.sck),
      .rst_n (rst_n),
      .d     ({tx_tgl_q, quad_enable, width}),
      .q     (lk_sync)
   );
   wire       tx_t_s = lk_sync[3];
   wire       qe_s   = lk_sync[2];
   wire [1:0] w_s    = lk_sync[1:0];

   // Quad width needs quad enable; otherwise fall back to single line
   wire [1:0] eff_w = (w_s == SFPC_W4 && !qe_s) ? SFPC_W1 : w_s; // (RULE6)
   wire [3:0] nb    = sfpc_nbits(eff_w);

   // Status write gate
   wire wp_block = status_write_disable & ~wp_n_s & ~quad_enable; // (RULE7) (RULE8) (RULE9)

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_q        <= SFPC_STAT_RST;
         stat_wr_rej_q <= 1'b0;
      end else begin
         stat_wr_rej_q <= stat_wr & wp_block; // (RULE7)
         if (stat_wr && !wp_block) begin
            stat_q <= stat_wdata & SFPC_STAT_MASK; // (RULE8)
         end
      end
   end

   // Transmit byte is held stable until the link picks it up by the toggle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_hold_q <= 8'h00;
         tx_tgl_q  <= 1'b0;
      end else if (tx_load) begin
         tx_hold_q <= tx_byte;
         tx_tgl_q  <= ~tx_tgl_q;
      end
   end

   // Received byte: the link word is stable for a whole byte time after its toggle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_seen_q  <= 1'b0;
         rx_valid_q <= 1'b0;
         rx_byte_q  <= 8'h00;
      end else begin
         rx_seen_q  <= rx_t_s;
         rx_valid_q <= rx_t_s ^ rx_seen_q;
         if (rx_t_s ^ rx_seen_q) begin
            rx_byte_q <= rx_word_q;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reset_active_q <= 1'b0;
         paused_q       <= 1'b0;
      end else begin
         reset_active_q <= rst_s;
         paused_q       <= hold_s;
      end
   end

   // Armed by the first rising select after power-up
   always_ff @(posedge bus.cs_n or negedge rst_n) begin
      if (!rst_n) begin
         armed_q <= 1'b0;
      end else begin
         armed_q <= 1'b1; // (RULE2)
      end
   end

   wire take = armed_q & ~hold_act; // (RULE2) (RULE14) (RULE16)

   // Receive shift on rising edges, width bits per edge
   logic [7:0] rx_sh_d;
   always_comb begin
      rx_sh_d = {rx_sh_q[6:0], bus.dl[0]}; // (RULE4)
      unique case (eff_w)
         SFPC_W2: rx_sh_d = {rx_sh_q[5:0], bus.dl[1:0]}; // (RULE5)
         SFPC_W4: rx_sh_d = {rx_sh_q[3:0], bus.dl[3:0]}; // (RULE5) (RULE6)
         default: rx_sh_d = {rx_sh_q[6:0], bus.dl[0]};
      endcase
   end
   wire [3:0] rx_sum  = {1'b0, rx_cnt_q} + nb;
   wire       rx_done = rx_sum[3];

   // Rising edge in both clock modes; idle level is never sampled
   always_ff @(posedge bus.sck or negedge link_rst_n) begin
      if (!link_rst_n) begin
         rx_sh_q  <= 8'h00;
         rx_cnt_q <= 3'h0;
      end else if (take) begin
         rx_sh_q  <= rx_sh_d; // (RULE4) (RULE19)
         rx_cnt_q <= rx_sum[2:0];
      end
   end

   // Word and toggle survive deselect so a finished byte is not lost
   always_ff @(posedge bus.sck or negedge rst_n) begin
      if (!rst_n) begin
         rx_word_q <= 8'h00;
         rx_tgl_q  <= 1'b0;
      end else if (take && rx_done && link_rst_n) begin
         rx_word_q <= rx_sh_d;
         rx_tgl_q  <= ~rx_tgl_q;
      end
   end

   // Transmit on falling edges; a byte starts only at a byte boundary
   wire       tx_pend  = tx_t_s ^ tx_ack_q;
   // A zero receive count marks the byte boundary, so read data lines up with whole bytes
   wire       tx_start = (tx_cnt_q == 3'h0) & (rx_cnt_q == 3'h0) & tx_pend & take;
   wire [3:0] tx_sum   = {1'b0, tx_cnt_q} + nb;

   always_ff @(negedge bus.sck or negedge link_rst_n) begin
      if (!link_rst_n) begin
         tx_sh_q  <= 8'h00;
         tx_cnt_q <= 3'h0;
         tx_act_q <= 1'b0;
      end else if (take) begin
         if (tx_cnt_q == 3'h0) begin
            tx_act_q <= tx_start;
            tx_sh_q  <= tx_hold_q;
            tx_cnt_q <= tx_start ? nb[2:0] : 3'h0;
         end else begin
            tx_sh_q  <= tx_sh_q << nb; // (RULE4) (RULE5)
            tx_cnt_q <= tx_sum[2:0];
         end
      end
   end

   always_ff @(negedge bus.sck or negedge rst_n) begin
      if (!rst_n) begin
         tx_ack_q <= 1'b0;
      end else if (tx_start && link_rst_n) begin
         tx_ack_q <= tx_t_s;
      end
   end

   // Line drive: single uses line 1, dual lines 0-1, quad all four
   logic [3:0] oe_mask;
   logic [3:0] out_bits;
   always_comb begin
      oe_mask  = 4'h2;
      out_bits = {2'h0, tx_sh_q[7], 1'b0};
      unique case (eff_w)
         SFPC_W2: begin
            oe_mask  = 4'h3; // (RULE5)
            out_bits = {2'h0, tx_sh_q[7:6]};
         end
         SFPC_W4: begin
            oe_mask  = 4'hF; // (RULE6)
            out_bits = tx_sh_q[7:4];
         end
         default: begin
            oe_mask  = 4'h2; // (RULE4)
            out_bits = {2'h0, tx_sh_q[7], 1'b0};
         end
      endcase
   end

   wire drive = tx_act_q & ~hold_act & ~bus.cs_n & ~rst_pin_act; // (RULE1) (RULE15) (RULE18)
   assign bus.d_o  = out_bits;
   assign bus.d_oe = drive ? oe_mask : 4'h0;

   assign rx_byte      = rx_byte_q;
   assign rx_valid     = rx_valid_q;
   assign stat         = stat_q;
   assign stat_wr_rej  = stat_wr_rej_q;
   assign reset_active = reset_active_q;
   assign paused       = paused_q;
endmodule // sfpc_flash

//--- sfpc_pkg.sv
// Shared constants, encodings and helpers for the serial flash pin control block
package sfpc_pkg;
   // Data line count and bus width encodings
   localparam int         SFPC_DL_W = 4;
   localparam logic [1:0] SFPC_W1   = 2'h0;
   localparam logic [1:0] SFPC_W2   = 2'h1;
   localparam logic [1:0] SFPC_W4   = 2'h2;
   // Status register field positions and reset value
   localparam int         SFPC_SWD_BIT   = 7;
   localparam int         SFPC_QE_BIT    = 6;
   localparam int         SFPC_BP_LSB    = 2;
   localparam int         SFPC_BP_W      = 4;
   localparam logic [7:0] SFPC_STAT_MASK = 8'hFC;
   localparam logic [7:0] SFPC_STAT_RST  = 8'h00;
   // Function register bit that disables the dedicated reset pin
   localparam int         SFPC_FUNC_RSTDIS_BIT = 0;
   // Line positions of the shared pins
   localparam int         SFPC_WP_LINE   = 2;
   localparam int         SFPC_HOLD_LINE = 3;
   // Link clock timing
   localparam int         SFPC_CLK_PERIOD_NS = 8;
   localparam int         SFPC_SCK_PERIOD_NS = 160;
   localparam int         SFPC_SCK_HALF_CYC  = SFPC_SCK_PERIOD_NS / (2 * SFPC_CLK_PERIOD_NS);
   localparam int         SFPC_SYNC_STAGES   = 3;

   // Bits moved per clock edge for a width code
   function automatic logic [3:0] sfpc_nbits(input logic [1:0] w);
      unique case (w)
         SFPC_W2: sfpc_nbits = 4'h2;
         SFPC_W4: sfpc_nbits = 4'h4;
         default: sfpc_nbits = 4'h1;
      endcase
   endfunction
endpackage

//--- sfpc_if.sv
// Pin-level link between the flash end and the master end
`timescale 1ns/1ps
interface sfpc_if;
   logic       sck;
   logic       cs_n;
   logic       reset_n;
   logic [3:0] m_o;
   logic [3:0] m_oe;
   logic [3:0] d_o;
   logic [3:0] d_oe;
   wire  [3:0] dl;

   // Wire level from the enables; undriven lines float high through the pull-up
   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_line
         assign dl[i] = d_oe[i] ? d_o[i] : (m_oe[i] ? m_o[i] : 1'b1);
      end
   endgenerate

   modport host  (output sck, output cs_n, output reset_n, output m_o, output m_oe, input dl);
   modport flash (input sck, input cs_n, input reset_n, input dl, output d_o, output d_oe);
endinterface

//--- sfpc_sync.sv
// Three-stage synchroniser; a change is passed on once stages two and three agree
`timescale 1ns/1ps
module sfpc_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] q_q;
   wire  [WIDTH-1:0] agree = s2_q ~^ s3_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         q_q  <= '0;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         q_q  <= (agree & s3_q) | (~agree & q_q);
      end
   end

   assign q = q_q;
endmodule // sfpc_sync

//--- sfpc_host.sv
// Master end: makes the link clock, selects, shifts bytes, pauses and resets
`timescale 1ns/1ps
module sfpc_host import sfpc_pkg::*; #(
   parameter int HALF = SFPC_SCK_HALF_CYC,
   parameter bit CPOL = 1'b0
) (
   sfpc_if.host            bus,
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       req,
   input  wire logic [1:0] req_width,
   input  wire logic       req_rd,
   input  wire logic       req_last,
   input  wire logic [7:0] req_tx,
   input  wire logic       pause_req,
   input  wire logic       wp_level,
   input  wire logic       hw_reset_req,
   output logic            busy,
   output logic            done,
   output logic      [7:0] rx_data
);
   typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_HOLD, H_END} sfpc_hstate_e;

   generate
      if (HALF < 8) begin : g_chk
         $error("HALF must cover the input synchroniser delay");
      end
   endgenerate

   sfpc_hstate_e st_q;
   logic [15:0]  div_q;
   logic [3:0]   cnt_q;
   logic [7:0]   tx_sh_q;
   logic [7:0]   rx_sh_q;
   logic [7:0]   rx_data_q;
   logic [1:0]   w_q;
   logic         rd_q;
   logic         last_q;
   logic         cs_n_q;
   logic         hold_n_q;
   logic         rst_n_q;
   logic         done_q;
   logic [3:0]   dl_s;

   sfpc_sync #(.WIDTH(4)) u_sync_dl (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (bus.dl),
      .q     (dl_s)
   );

   wire       half_end = (div_q == 16'(HALF - 1));
   wire [3:0] nb       = sfpc_nbits(w_q);
   wire [3:0] cnt_sum  = cnt_q + nb;
   logic [7:0] rx_sh_d;
   always_comb begin
      rx_sh_d = {rx_sh_q[6:0], dl_s[1]};
      unique case (w_q)
         SFPC_W2: rx_sh_d = {rx_sh_q[5:0], dl_s[1:0]};
         SFPC_W4: rx_sh_d = {rx_sh_q[3:0], dl_s[3:0]};
         default: rx_sh_d = {rx_sh_q[6:0], dl_s[1]};
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q     <= H_IDLE;
         div_q    <= 16'h0000;
         cnt_q    <= 4'h0;
         tx_sh_q  <= 8'h00;
         rx_sh_q  <= 8'h00;
         rx_data_q <= 8'h00;
         w_q      <= SFPC_W1;
         rd_q     <= 1'b0;
         last_q   <= 1'b1;
         cs_n_q   <= 1'b1;
         hold_n_q <= 1'b1;
         done_q   <= 1'b0;
      end else begin
         done_q <= 1'b0;
         div_q  <= half_end ? 16'h0000 : div_q + 16'h0001;
         unique case (st_q)
            H_IDLE: begin
               div_q <= 16'h0000;
               if (req) begin
                  st_q    <= H_LOW;
                  cs_n_q  <= 1'b0;
                  tx_sh_q <= req_tx;
                  w_q     <= req_width;
                  rd_q    <= req_rd;
                  last_q  <= req_last;
                  cnt_q   <= 4'h0;
               end
            end
            H_LOW: begin
               if (half_end) begin
                  // Pause only with the clock low, never in quad width
                  if (pause_req && w_q != SFPC_W4) begin // (RULE20)
                     st_q     <= H_HOLD;
                     hold_n_q <= 1'b0;
                  end else begin
                     st_q    <= H_HIGH;
                     rx_sh_q <= rx_sh_d;
                     cnt_q   <= cnt_sum;
                  end
               end
            end
            H_HOLD: begin
               if (half_end && !pause_req) begin // (RULE16)
                  st_q     <= H_LOW;
                  hold_n_q <= 1'b1;
               end
            end
            H_HIGH: begin
               if (half_end) begin
                  st_q    <= cnt_q[3] ? H_END : H_LOW;
                  tx_sh_q <= tx_sh_q << nb;
               end
            end
            H_END: begin
               done_q    <= 1'b1;
               rx_data_q <= rx_sh_q;
               cs_n_q    <= last_q;
               st_q      <= H_IDLE;
            end
            default: st_q <= H_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_n_q <= 1'b1;
      end else begin
         rst_n_q <= ~hw_reset_req;
      end
   end

   wire in_frame = (st_q == H_LOW) | (st_q == H_HIGH) | (st_q == H_HOLD);
   logic [3:0] m_o;
   logic [3:0] m_oe;
   always_comb begin
      m_o  = {hold_n_q, wp_level, 1'b0, tx_sh_q[7]};
      m_oe = 4'hC;
      unique case (w_q)
         SFPC_W2: begin
            m_o  = {hold_n_q, wp_level, tx_sh_q[7:6]};
            m_oe = rd_q ? 4'hC : 4'hF;
         end
         SFPC_W4: begin
            m_o  = tx_sh_q[7:4];
            m_oe = rd_q ? 4'h0 : 4'hF;
         end
         default: begin
            m_o  = {hold_n_q, wp_level, 1'b0, tx_sh_q[7]};
            m_oe = 4'hD;
         end
      endcase
      if (!in_frame && w_q == SFPC_W4) begin
         m_oe = 4'h0;
      end
   end

   assign bus.sck     = (st_q == H_HIGH) | (((st_q == H_IDLE) | (st_q == H_END)) & CPOL);
   assign bus.cs_n    = cs_n_q;
   assign bus.reset_n = rst_n_q;
   assign bus.m_o     = m_o;
   assign bus.m_oe    = m_oe;
   assign busy        = (st_q != H_IDLE);
   assign done        = done_q;
   assign rx_data     = rx_data_q;
endmodule // sfpc_host

//--- sfpc_link_checker.sv
// Concurrent checks on the link between the host end and the flash end
`timescale 1ns/1ps
module sfpc_link_checker #(
   parameter bit CPOL = 1'b0
) (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       sck,
   input wire logic       cs_n,
   input wire logic       reset_n,
   input wire logic [3:0] m_o,
   input wire logic [3:0] m_oe,
   input wire logic [3:0] d_o,
   input wire logic [3:0] d_oe,
   input wire logic [3:0] dl
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_desel_quiet: assert property (cs_n |-> d_oe == 4'h0)
      else $error("flash drives a line while deselected");
   a_sck_idle: assert property (cs_n |-> sck == CPOL)
      else $error("link clock not at idle level outside a frame");
   a_sck_still: assert property (cs_n && $past(cs_n) |-> $stable(sck))
      else $error("link clock moves outside a frame");
   a_host_launch_low: assert property (sck && $past(sck) |-> $stable(m_o))
      else $error("host data changed while link clock high");
   a_flash_launch_fall: assert property (
      !cs_n && reset_n && sck && $past(sck) |-> $stable(d_o & d_oe))
      else $error("flash data changed while link clock high");
   a_quad_mask: assert property (d_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
      else $error("flash enables an illegal set of lines");
   // Quad turnaround lets the flash drive line 3 over the host; that case is excluded
   a_pause_quiet: assert property (
      !cs_n && m_oe[3] && !dl[3] && !d_oe[3] |-> d_oe == 4'h0)
      else $error("flash drives while paused");
   a_pause_edge_low: assert property ($changed(m_o[3]) && m_oe[3] |-> !sck)
      else $error("shared line changed while link clock high");
   a_reset_quiet: assert property (!reset_n |-> d_oe == 4'h0)
      else $error("flash drives during reset");
endmodule // sfpc_link_checker

//--- serial_flash_pin_control_tb_top.sv
// Self-checking bench: host end and flash end joined on one link
`timescale 1ns/1ps
module serial_flash_pin_control_tb_top import sfpc_pkg::*;;
   logic        clk, rst_n, stat_wr, pin_select_bit, tx_load, rx_valid, stat_wr_rej;
   logic        reset_active, paused, req, req_rd, req_last, pause_req, wp_level;
   logic        hw_reset_req, busy, done, pause_seen;
   logic [1:0]  width, req_width;
   logic [7:0]  stat_wdata, func_reg, tx_byte, rx_byte, stat, req_tx, rx_data, rx_last;
   logic [31:0] seed;
   int          n_mismatch, n_checks, rx_cnt, rej_cnt, k;

   sfpc_if lnk ();
   sfpc_flash #(.HAS_DED_RESET(1'b1)) sfpc_flash_inst (
      .bus(lnk), .clk(clk), .rst_n(rst_n), .width(width), .stat_wr(stat_wr),
      .stat_wdata(stat_wdata), .func_reg(func_reg), .pin_select_bit(pin_select_bit),
      .tx_byte(tx_byte), .tx_load(tx_load), .rx_byte(rx_byte), .rx_valid(rx_valid),
      .stat(stat), .stat_wr_rej(stat_wr_rej), .reset_active(reset_active), .paused(paused));
   sfpc_host #(.HALF(10), .CPOL(1'b0)) sfpc_host_inst (
      .bus(lnk), .clk(clk), .rst_n(rst_n), .req(req), .req_width(req_width),
      .req_rd(req_rd), .req_last(req_last), .req_tx(req_tx), .pause_req(pause_req),
      .wp_level(wp_level), .hw_reset_req(hw_reset_req), .busy(busy), .done(done),
      .rx_data(rx_data));
   sfpc_link_checker #(.CPOL(1'b0)) sfpc_link_checker_inst (
      .clk(clk), .rst_n(rst_n), .sck(lnk.sck), .cs_n(lnk.cs_n), .reset_n(lnk.reset_n),
      .m_o(lnk.m_o), .m_oe(lnk.m_oe), .d_o(lnk.d_o), .d_oe(lnk.d_oe), .dl(lnk.dl));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(posedge clk) begin
      if (rx_valid === 1'b1) begin
         rx_last <= rx_byte;
         rx_cnt  <= rx_cnt + 1;
      end
      if (stat_wr_rej === 1'b1) rej_cnt <= rej_cnt + 1;
      if (paused === 1'b1) pause_seen <= 1'b1;
   end

   function automatic logic [7:0] rnd8();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction

   // Status write goes through unless the protect bit, a low pin and no quad enable meet
   function automatic logic stat_ok(input logic swd, input logic qe, input logic wp);
      return !(swd && !wp && !qe);
   endfunction

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic xfer(input logic [1:0] w, input logic rd, input logic last,
                       input logic [7:0] d);
      int t;
      @(negedge clk);
      req = 1'b1;
      req_width = w;
      req_rd = rd;
      req_last = last;
      req_tx = d;
      @(negedge clk);
      req = 1'b0;
      check("busy", 8'h01, {7'h00, busy});
      t = 0;
      while (done !== 1'b1 && t < 3000) begin
         @(negedge clk);
         t++;
      end
      check("done seen", 8'h01, {7'h00, t < 3000});
   endtask

   task automatic wr_byte(input logic [1:0] w, input logic last, input logic [7:0] d,
                          input logic take);
      int c0;
      c0 = rx_cnt;
      xfer(w, 1'b0, last, d);
      repeat (4) @(negedge clk);
      check("rx count", {7'h00, take}, 8'(rx_cnt - c0));
      if (take) check("rx byte", d, rx_last);
   endtask

   task automatic rd_pair(input logic [1:0] w);
      logic [7:0] d;
      d = rnd8();
      tx_byte = d;
      tx_load = 1'b1;
      @(negedge clk);
      tx_load = 1'b0;
      // Pickup needs four link edges and a byte boundary: quad takes two command frames
      repeat (w == SFPC_W4 ? 2 : 1) xfer(w, 1'b0, 1'b0, rnd8());
      xfer(w, 1'b1, 1'b1, 8'h00);
      check("read byte", d, rx_data);
   endtask

   // Config crosses on link clock edges; two throwaway frames give quad its four edges
   task automatic settle(input logic [1:0] w);
      width = w;
      repeat (2) xfer(w, 1'b0, 1'b1, 8'hA5);
   endtask

   task automatic stat_write(input logic [7:0] d);
      stat_wdata = d;
      stat_wr = 1'b1;
      @(negedge clk);
      stat_wr = 1'b0;
      repeat (4) @(negedge clk);
   endtask

   task automatic do_reset();
      rst_n = 1'b0;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      check("stat reset", SFPC_STAT_RST, stat);
      width = SFPC_W1;
      wr_byte(SFPC_W1, 1'b1, 8'h3C, 1'b0);
      wr_byte(SFPC_W1, 1'b1, 8'hC3, 1'b1);
   endtask

   task automatic pause_try(input logic dis, input logic psel);
      logic [7:0] d;
      logic       is_rst;
      d = rnd8();
      is_rst = dis & psel;
      func_reg = {7'h00, dis};
      pin_select_bit = psel;
      settle(SFPC_W1);
      fork
         xfer(SFPC_W1, 1'b0, 1'b1, d);
         begin
            repeat (50) @(negedge clk);
            pause_req = 1'b1;
            repeat (100) @(negedge clk);
            check("paused", {7'h00, !is_rst}, {7'h00, paused});
            check("shared reset", {7'h00, is_rst}, {7'h00, reset_active});
            pause_req = 1'b0;
         end
      join
      if (!is_rst) check("paused byte", d, rx_last);
   endtask

   initial begin
      #600000;
      n_mismatch++;
      $display("BAD watchdog expected finish seen timeout");
      test_done();
   end

   initial begin
      logic [7:0] d;
      int         c;
      {rst_n, stat_wr, tx_load, req, req_rd, req_last, pause_req, hw_reset_req} = '0;
      {width, req_width, stat_wdata, tx_byte, req_tx, pin_select_bit, func_reg} = '0;
      {rx_last, pause_seen, n_mismatch, n_checks, rx_cnt, rej_cnt} = '0;
      wp_level = 1'b1;
      seed = 32'h00000058;
      @(negedge clk);
      do_reset();
      for (k = 0; k < 2; k++) begin
         settle(k[0] ? SFPC_W2 : SFPC_W1);
         repeat (3) wr_byte(width, 1'b0, rnd8(), 1'b1);
         wr_byte(width, 1'b0, 8'h00, 1'b1);
         wr_byte(width, 1'b1, 8'hFF, 1'b1);
         repeat (2) rd_pair(width);
      end
      settle(SFPC_W1);
      for (k = 0; k < 8; k++) begin
         wp_level = 1'b1;
         repeat (8) @(negedge clk);
         stat_write({k[2], k[1], 6'h00});
         wp_level = k[0];
         repeat (8) @(negedge clk);
         c = rej_cnt;
         d = rnd8();
         stat_write(d);
         check("stat", stat_ok(k[2], k[1], k[0]) ? d & SFPC_STAT_MASK : {k[2], k[1], 6'h00},
               stat);
         check("reject", {7'h00, !stat_ok(k[2], k[1], k[0])}, 8'(rej_cnt - c));
      end
      wp_level = 1'b1;
      stat_write(8'h00);
      for (k = 0; k < 2; k++) begin
         func_reg = {7'h00, k[0]};
         repeat (20) @(negedge clk);
         hw_reset_req = 1'b1;
         repeat (20) @(negedge clk);
         check("pin reset", {7'h00, !k[0]}, {7'h00, reset_active});
         hw_reset_req = 1'b0;
         repeat (20) @(negedge clk);
         check("pin reset off", 8'h00, {7'h00, reset_active});
      end
      for (k = 0; k < 4; k++) pause_try(k[1], k[0]);
      func_reg = 8'h00;
      pin_select_bit = 1'b0;
      do_reset();
      stat_write(8'h40);
      pause_seen = 1'b0;
      pause_req = 1'b1;
      settle(SFPC_W4);
      repeat (4) wr_byte(SFPC_W4, 1'b0, rnd8(), 1'b1);
      wr_byte(SFPC_W4, 1'b1, 8'h00, 1'b1);
      repeat (2) rd_pair(SFPC_W4);
      check("quad no pause", 8'h00, {7'h00, pause_seen});
      pause_req = 1'b0;
      test_done();
   end
endmodule // serial_flash_pin_control_tb_top
